// ---- dtb_consts.vh ----
// constants for the disc tag-and-bus command port
// Overview of operation
// - write-protect on bus-in bit 4; writing while protected sets fault
// - protect from board switch, panel switch, fault or lost motor speed
// - address-mark bit goes high when a mark is found during search
// - index once per revolution from servo, sector zero start, switch suppressible
// - sector marks from servo, count set by switches, switch suppressible
// - head-select tag loads bus-out bits 0-4 as head address; 5,6,9 ignored
// - extended head-select loads bus-out bits 7,8 as cylinder bits 10,11
// - seek beyond maximum legal cylinder sets seek error instead of moving
// - drive status is on bus-in at all times, whether or not head-select or control-select is active
// - control-select routes bus-out to control logic, lines choose operation
// - cylinder-select loads bus-out bits 0-9 and starts a seek
// - status: ready bit 0, on-cylinder 1, seek error 2, fault 3
// - return-to-zero clears seek error unless a drive seek error arrives in the same cycle, seeks cylinder zero, clears addresses
// - write or read gate refused while seek error or fault present
`ifndef DTB_CONSTS_VH
`define DTB_CONSTS_VH
// register byte offsets
`define DTB_REG_CONFIG 8'h00
`define DTB_REG_STATUS 8'h04
`define DTB_REG_ADDR 8'h08
`define DTB_REG_MAXCYL 8'h0C
`define DTB_REG_IRQ_STAT 8'h10
`define DTB_REG_IRQ_CLR 8'h14
`define DTB_REG_IRQ_EN 8'h18
// config fields
`define DTB_CFG_EXT_BIT 0
`define DTB_CFG_IDX_OFF_BIT 1
`define DTB_CFG_SEC_OFF_BIT 2
`define DTB_CFG_PROT_BIT 3
`define DTB_CFG_SPS_LSB 8
`define DTB_CFG_SPS_MSB 15
`define DTB_CFG_RESET 32'h0000_0400
`define DTB_MAXCYL_RESET 12'h662
// bus-out control lines under control select
`define DTB_CTL_WGATE 0
`define DTB_CTL_RGATE 1
`define DTB_CTL_OFS_P 2
`define DTB_CTL_OFS_M 3
`define DTB_CTL_FCLR 4
`define DTB_CTL_AMEN 5
`define DTB_CTL_RTZ 6
`define DTB_CTL_EARLY 7
`define DTB_CTL_LATE 8
`define DTB_CTL_REL 9
// interrupt event bits
`define DTB_EV_SEEK 0
`define DTB_EV_SEEKERR 1
`define DTB_EV_FAULT 2
`define DTB_EV_AMARK 3
`define DTB_EV_INDEX 4
`define DTB_EV_W 5
// axi responses
`define DTB_RESP_OKAY 2'h0
`define DTB_RESP_SLVERR 2'h2
`endif

// ---- dtb_sync.v ----
// two-flop synchroniser for tag and bus-out lines
`timescale 1ns/1ns
`default_nettype none
module dtb_sync #(
	parameter W = 1
) (
	// clock and reset
	input wire aclk,
	input wire aresetn,
	// raw and synchronised lines
	input wire [W-1:0] d,
	output reg [W-1:0] q
);
	reg [W-1:0] meta_q;

	// first stage feeds only the second
	always @(posedge aclk) begin
		if (!aresetn) begin
			meta_q <= {W{1'b0}};
			q <= {W{1'b0}};
		end else begin
			meta_q <= d;
			q <= meta_q;
		end
	end
endmodule // dtb_sync
`default_nettype wire

// ---- dtb_port.v ----
// drive-side tag and bus command port with axi4-lite register access
//
// Decided for this implementation: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
`default_nettype none
`include "dtb_consts.vh"
module dtb_port (
	// clock and reset
	input wire aclk,
	input wire aresetn,
	// controller tag and bus lines
	input wire tag_cyl,
	input wire tag_head,
	input wire tag_ctl,
	input wire [9:0] bus_out,
	output reg [7:0] bus_in_q,
	// drive side
	input wire panel_protect_sw,
	input wire motor_speed_ok,
	input wire first_seek_ok,
	input wire on_cylinder,
	input wire fault_in,
	input wire seek_error_in,
	input wire servo_index,
	input wire servo_slot,
	input wire amark_found,
	output reg seek_start_q,
	output reg [11:0] seek_cyl_q,
	output reg [4:0] head_q,
	output reg write_gate_q,
	output reg read_gate_q,
	output reg amark_enable_q,
	output reg offset_plus_q,
	output reg offset_minus_q,
	output reg strobe_early_q,
	output reg strobe_late_q,
	output reg release_q,
	// axi4-lite slave
	input wire [7:0] s_awaddr,
	input wire s_awvalid,
	output reg s_awready,
	input wire [31:0] s_wdata,
	input wire [3:0] s_wstrb,
	input wire s_wvalid,
	output reg s_wready,
	output reg [1:0] s_bresp,
	output reg s_bvalid,
	input wire s_bready,
	input wire [7:0] s_araddr,
	input wire s_arvalid,
	output reg s_arready,
	output reg [31:0] s_rdata,
	output reg [1:0] s_rresp,
	output reg s_rvalid,
	input wire s_rready,
	// interrupt
	output reg irq_q
);
	// byte-lane merge for register writes
	function [31:0] merge;
		input [31:0] old;
		input [31:0] nw;
		input [3:0] strb;
		integer i;
		begin
			merge = old;
			for (i = 0; i < 4; i = i + 1)
				if (strb[i])
					merge[i*8 +: 8] = nw[i*8 +: 8];
		end
	endfunction

	// known register offsets
	function known;
		input [7:0] a;
		begin
			known = (a == `DTB_REG_CONFIG) || (a == `DTB_REG_STATUS) ||
				(a == `DTB_REG_ADDR) || (a == `DTB_REG_MAXCYL) ||
				(a == `DTB_REG_IRQ_STAT) || (a == `DTB_REG_IRQ_CLR) ||
				(a == `DTB_REG_IRQ_EN);
		end
	endfunction

	wire [12:0] sync_q;
	reg [2:0] tag_d_q;
	reg [31:0] cfg_q;
	reg [11:0] maxcyl_q;
	reg [11:0] cyl_q;
	reg seekerr_q;
	reg fault_q;
	reg amark_q;
	reg index_q;
	reg sector_q;
	reg [7:0] slot_cnt_q;
	reg [`DTB_EV_W-1:0] irq_stat_q;
	reg [`DTB_EV_W-1:0] irq_en_q;
	reg [`DTB_EV_W-1:0] ev;
	reg aw_have_q;
	reg w_have_q;
	reg [7:0] awaddr_q;
	reg [31:0] wdata_q;
	reg [3:0] wstrb_q;

	// tags and bus-out pass two flops before any logic sees them
	dtb_sync #(.W(13)) u_sync (
		.aclk(aclk),
		.aresetn(aresetn),
		.d({tag_ctl, tag_head, tag_cyl, bus_out}),
		.q(sync_q)
	);

	wire [9:0] bus_s = sync_q[9:0];
	wire cyl_s = sync_q[10];
	wire head_s = sync_q[11];
	wire ctl_s = sync_q[12];
	wire cyl_rise = cyl_s & ~tag_d_q[0];
	wire head_rise = head_s & ~tag_d_q[1];
	wire ctl_rise = ctl_s & ~tag_d_q[2];
	wire ext_mode = cfg_q[`DTB_CFG_EXT_BIT];
	wire [7:0] sps = cfg_q[`DTB_CFG_SPS_MSB:`DTB_CFG_SPS_LSB];

	// write protection sources
	wire protect = cfg_q[`DTB_CFG_PROT_BIT] | panel_protect_sw | fault_q |
		~motor_speed_ok;
	wire unit_ready = motor_speed_ok & first_seek_ok & ~fault_q;
	// seek target: high bits come from the last extended head-select, and only in extended mode
	wire [11:0] target = ext_mode ? {cyl_q[11:10], bus_s} : {2'h0, bus_s};
	wire bad_cyl = target > maxcyl_q;
	wire ctl_go = ctl_s;
	wire blocked = seekerr_q | fault_q;
	wire want_wr = ctl_go & bus_s[`DTB_CTL_WGATE];
	wire want_rd = ctl_go & bus_s[`DTB_CTL_RGATE];
	wire wr_prot_hit = want_wr & protect;
	wire rtz = ctl_rise & bus_s[`DTB_CTL_RTZ];
	wire am_search = read_gate_q & amark_enable_q;
	wire seekerr_set = (cyl_rise & bad_cyl & ~rtz) | seek_error_in;
	wire [31:0] maxcyl_wr = merge({20'h0, maxcyl_q}, wdata_q, wstrb_q);

	// status word, same for every tag held
	wire [7:0] status_word = {sector_q, index_q, amark_q, protect, fault_q,
		seekerr_q, on_cylinder, unit_ready};

	// tag edge history from the synchronised lines
	always @(posedge aclk) begin
		if (!aresetn)
			tag_d_q <= 3'h0;
		else
			tag_d_q <= {ctl_s, head_s, cyl_s};
	end

	// head and cylinder address capture and seek start
	always @(posedge aclk) begin
		if (!aresetn) begin
			head_q <= 5'h00;
			cyl_q <= 12'h000;
			seek_cyl_q <= 12'h000;
			seek_start_q <= 1'b0;
			seekerr_q <= 1'b0;
		end else begin
			seek_start_q <= 1'b0;
			if (rtz) begin
				head_q <= 5'h00;
				cyl_q <= 12'h000;
				seek_cyl_q <= 12'h000;
				seek_start_q <= 1'b1;
				seekerr_q <= 1'b0;
			end else begin
				if (head_rise) begin
					head_q <= bus_s[4:0];
					if (ext_mode)
						cyl_q[11:10] <= bus_s[8:7];
				end
				if (cyl_rise) begin
					cyl_q[9:0] <= bus_s;
					if (!ext_mode)
						cyl_q[11:10] <= 2'h0;
					if (!bad_cyl) begin
						seek_cyl_q <= target;
						seek_start_q <= 1'b1;
					end
				end
			end
			// a drive seek error arriving with a return-to-zero still sticks: set wins
			if (seekerr_set)
				seekerr_q <= 1'b1;
		end
	end

	// fault latch: set wins, clear only once the cause has gone
	always @(posedge aclk) begin
		if (!aresetn)
			fault_q <= 1'b0;
		else if (fault_in || wr_prot_hit)
			fault_q <= 1'b1;
		else if (ctl_rise && bus_s[`DTB_CTL_FCLR])
			fault_q <= 1'b0;
	end

	// control-select operations; gates are levels held with the tag
	always @(posedge aclk) begin
		if (!aresetn) begin
			write_gate_q <= 1'b0;
			read_gate_q <= 1'b0;
			amark_enable_q <= 1'b0;
			offset_plus_q <= 1'b0;
			offset_minus_q <= 1'b0;
			strobe_early_q <= 1'b0;
			strobe_late_q <= 1'b0;
			release_q <= 1'b0;
		end else begin
			write_gate_q <= want_wr & ~blocked & ~protect;
			read_gate_q <= want_rd & ~blocked;
			amark_enable_q <= ctl_go & bus_s[`DTB_CTL_AMEN];
			offset_plus_q <= ctl_go & bus_s[`DTB_CTL_OFS_P];
			offset_minus_q <= ctl_go & bus_s[`DTB_CTL_OFS_M];
			strobe_early_q <= ctl_go & bus_s[`DTB_CTL_EARLY];
			strobe_late_q <= ctl_go & bus_s[`DTB_CTL_LATE];
			release_q <= ctl_rise & bus_s[`DTB_CTL_REL];
		end
	end

	// address mark: found during search sets it, ending the search clears it
	always @(posedge aclk) begin
		if (!aresetn)
			amark_q <= 1'b0;
		else if (am_search && amark_found)
			amark_q <= 1'b1;
		else if (!am_search)
			amark_q <= 1'b0;
	end

	// index and sector marks from servo timing; index restarts the count
	always @(posedge aclk) begin
		if (!aresetn) begin
			index_q <= 1'b0;
			sector_q <= 1'b0;
			slot_cnt_q <= 8'h00;
		end else begin
			index_q <= servo_index & ~cfg_q[`DTB_CFG_IDX_OFF_BIT];
			sector_q <= 1'b0;
			if (servo_index) begin
				slot_cnt_q <= 8'h00;
				sector_q <= ~cfg_q[`DTB_CFG_SEC_OFF_BIT];
			end else if (servo_slot) begin
				if (slot_cnt_q >= sps - 8'h01) begin
					slot_cnt_q <= 8'h00;
					sector_q <= ~cfg_q[`DTB_CFG_SEC_OFF_BIT];
				end else begin
					slot_cnt_q <= slot_cnt_q + 8'h01;
				end
			end
		end
	end

	// bus-in always carries the drive status word
	always @(posedge aclk) begin
		if (!aresetn)
			bus_in_q <= 8'h00;
		else
			bus_in_q <= status_word;
	end

	// interrupt events
	always @* begin
		ev = {`DTB_EV_W{1'b0}};
		ev[`DTB_EV_SEEK] = seek_start_q;
		ev[`DTB_EV_SEEKERR] = seekerr_set;
		ev[`DTB_EV_FAULT] = fault_in | wr_prot_hit;
		ev[`DTB_EV_AMARK] = am_search & amark_found;
		ev[`DTB_EV_INDEX] = servo_index;
	end

	// axi write channel: address and data may come in either order
	always @(posedge aclk) begin
		if (!aresetn) begin
			aw_have_q <= 1'b0;
			w_have_q <= 1'b0;
			awaddr_q <= 8'h00;
			wdata_q <= 32'h0000_0000;
			wstrb_q <= 4'h0;
			s_awready <= 1'b0;
			s_wready <= 1'b0;
			s_bvalid <= 1'b0;
			s_bresp <= `DTB_RESP_OKAY;
			cfg_q <= `DTB_CFG_RESET;
			maxcyl_q <= `DTB_MAXCYL_RESET;
			irq_en_q <= {`DTB_EV_W{1'b0}};
			irq_stat_q <= {`DTB_EV_W{1'b0}};
		end else begin
			s_awready <= ~aw_have_q & ~(s_awvalid & s_awready) & ~s_bvalid;
			s_wready <= ~w_have_q & ~(s_wvalid & s_wready) & ~s_bvalid;
			if (s_awvalid && s_awready) begin
				aw_have_q <= 1'b1;
				awaddr_q <= s_awaddr;
			end
			if (s_wvalid && s_wready) begin
				w_have_q <= 1'b1;
				wdata_q <= s_wdata;
				wstrb_q <= s_wstrb;
			end
			if (s_bvalid && s_bready)
				s_bvalid <= 1'b0;
			// clear first so a same-cycle event still lands
			if (aw_have_q && w_have_q && !s_bvalid) begin
				aw_have_q <= 1'b0;
				w_have_q <= 1'b0;
				s_bvalid <= 1'b1;
				s_bresp <= known(awaddr_q) ? `DTB_RESP_OKAY : `DTB_RESP_SLVERR;
				if (awaddr_q == `DTB_REG_CONFIG)
					cfg_q <= merge(cfg_q, wdata_q, wstrb_q);
				else if (awaddr_q == `DTB_REG_MAXCYL)
					maxcyl_q <= maxcyl_wr[11:0];
				else if (awaddr_q == `DTB_REG_IRQ_EN)
					irq_en_q <= wdata_q[`DTB_EV_W-1:0];
				if (awaddr_q == `DTB_REG_IRQ_CLR)
					irq_stat_q <= (irq_stat_q & ~wdata_q[`DTB_EV_W-1:0]) | ev;
				else
					irq_stat_q <= irq_stat_q | ev;
			end else begin
				irq_stat_q <= irq_stat_q | ev;
			end
		end
	end

	// axi read channel: data one cycle after the address is taken
	always @(posedge aclk) begin
		if (!aresetn) begin
			s_arready <= 1'b0;
			s_rvalid <= 1'b0;
			s_rdata <= 32'h0000_0000;
			s_rresp <= `DTB_RESP_OKAY;
		end else begin
			s_arready <= ~s_rvalid & ~(s_arvalid & s_arready);
			if (s_arvalid && s_arready) begin
				s_rvalid <= 1'b1;
				s_rresp <= known(s_araddr) ? `DTB_RESP_OKAY : `DTB_RESP_SLVERR;
				if (s_araddr == `DTB_REG_CONFIG)
					s_rdata <= cfg_q;
				else if (s_araddr == `DTB_REG_STATUS)
					s_rdata <= {24'h0, status_word};
				else if (s_araddr == `DTB_REG_ADDR)
					s_rdata <= {11'h0, head_q, 4'h0, cyl_q};
				else if (s_araddr == `DTB_REG_MAXCYL)
					s_rdata <= {20'h0, maxcyl_q};
				else if (s_araddr == `DTB_REG_IRQ_STAT)
					s_rdata <= {27'h0, irq_stat_q};
				else if (s_araddr == `DTB_REG_IRQ_EN)
					s_rdata <= {27'h0, irq_en_q};
				else
					s_rdata <= 32'h0000_0000;
			end else if (s_rvalid && s_rready) begin
				s_rvalid <= 1'b0;
			end
		end
	end

	// level interrupt while any enabled status bit is set
	always @(posedge aclk) begin
		if (!aresetn)
			irq_q <= 1'b0;
		else
			irq_q <= |(irq_stat_q & irq_en_q);
	end
endmodule // dtb_port
`default_nettype wire

// ---- dtb_port_assertions.sv ----
// assertion checker for the tag-and-bus command port
`timescale 1ns/1ns
`default_nettype none
module dtb_port_chk (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// tag link
	input wire logic tag_cyl,
	input wire logic tag_head,
	input wire logic tag_ctl,
	input wire logic [9:0] bus_out,
	input wire logic [7:0] bus_in_q,
	// drive side
	input wire logic panel_protect_sw,
	input wire logic motor_speed_ok,
	input wire logic amark_found,
	input wire logic seek_start_q,
	input wire logic [11:0] seek_cyl_q,
	input wire logic [4:0] head_q,
	input wire logic write_gate_q,
	input wire logic read_gate_q,
	input wire logic amark_enable_q
);
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	// a head-select held with a steady bus, and a clean read request held
	sequence s_head;
		$rose(tag_head) ##1 (tag_head && $stable(bus_out))[*5];
	endsequence
	sequence s_rd;
		(tag_ctl && bus_out[1] && bus_in_q[3:2] == 2'b00)[*5];
	endsequence
	property p_prot;
		(panel_protect_sw || !motor_speed_ok) |-> ##[1:2] bus_in_q[4];
	endproperty
	a_prot: assert property (p_prot) else $error("protect not shown");
	property p_wpf;
		(tag_ctl && bus_out[0] && bus_in_q[4])[*4] |-> ##[0:3] bus_in_q[3];
	endproperty
	a_wpf: assert property (p_wpf) else $error("protected write no fault");
	property p_head;
		s_head |-> head_q == bus_out[4:0];
	endproperty
	a_head: assert property (p_head) else $error("head not loaded");
	property p_rd;
		s_rd |-> read_gate_q;
	endproperty
	a_rd: assert property (p_rd) else $error("read gate missing");
	// hazard: the status word lags the latch by one edge, so two samples are needed
	property p_gate;
		$past(|bus_in_q[3:2]) && |bus_in_q[3:2] |-> !write_gate_q && !read_gate_q;
	endproperty
	a_gate: assert property (p_gate) else $error("gate while in error");
	property p_seek;
		$rose(tag_cyl) |-> ##[1:6] (seek_start_q || bus_in_q[2]);
	endproperty
	a_seek: assert property (p_seek) else $error("no seek outcome");
	property p_amk;
		amark_found && read_gate_q && amark_enable_q |-> ##[1:3] bus_in_q[5];
	endproperty
	a_amk: assert property (p_amk) else $error("mark not shown");
	property p_rst;
		$rose(aresetn) |-> head_q == 5'h00 && seek_cyl_q == 12'h000 && !bus_in_q[5];
	endproperty
	a_rst: assert property (p_rst) else $error("reset state wrong");
endmodule // dtb_port_chk
bind dtb_port dtb_port_chk u_chk (.aclk, .aresetn, .tag_cyl, .tag_head, .tag_ctl, .bus_out,
	.bus_in_q, .panel_protect_sw, .motor_speed_ok, .amark_found, .seek_start_q,
	.seek_cyl_q, .head_q, .write_gate_q, .read_gate_q, .amark_enable_q);
`default_nettype wire

// ---- dtb_ctrl_model.sv ----
// controller model driving the tag lines and the outbound bus
`timescale 1ns/1ns
`default_nettype none
module dtb_ctrl_model (
	// clock and bench request
	input wire logic aclk,
	input wire logic go,
	input wire logic [1:0] kind,
	input wire logic [9:0] val,
	input wire logic [3:0] hold,
	// tag and bus lines
	output logic tag_cyl,
	output logic tag_head,
	output logic tag_ctl,
	output logic [9:0] bus_out
);
	logic [4:0] cnt_q = 5'h00;
	logic [1:0] kind_q = 2'h0;
	initial {tag_cyl, tag_head, tag_ctl, bus_out} = 13'h0000;
	// bus settles a cycle before the tag and stays put until the tag drops
	always @(posedge aclk) begin
		if (go && cnt_q == 5'h00) begin
			bus_out <= val;
			kind_q <= kind;
			cnt_q <= {1'b0, hold} + 5'h02;
		end else if (cnt_q != 5'h00) begin
			cnt_q <= cnt_q - 5'h01;
			{tag_ctl, tag_head, tag_cyl} <= (cnt_q > 5'h01) ? 3'b001 << kind_q : 3'b000;
			// a released bus must not look like the last value
			if (cnt_q == 5'h01) begin
				bus_out <= ~bus_out;
			end
		end
	end
endmodule // dtb_ctrl_model
`default_nettype wire

// ---- tb.sv ----
// self-checking bench for the tag-and-bus command port
`timescale 1ns/1ns
`default_nettype none
`include "dtb_consts.vh"
module tb;
	logic aclk = 1'b0, aresetn = 1'b0, go = 1'b0;
	logic [1:0] kind = 2'h0;
	logic [9:0] val = 10'h000;
	logic [3:0] hold = 4'h0;
	logic tag_cyl, tag_head, tag_ctl, seek_start_q, write_gate_q, read_gate_q, irq_q;
	logic amark_enable_q, offset_plus_q, offset_minus_q, strobe_early_q, strobe_late_q, release_q;
	logic [9:0] bus_out;
	logic [7:0] bus_in_q;
	logic panel_protect_sw = 1'b0, motor_speed_ok = 1'b1, on_cylinder = 1'b1, fault_in = 1'b0;
	logic servo_index = 1'b0, servo_slot = 1'b0, amark_found = 1'b0;
	logic [11:0] seek_cyl_q;
	logic [4:0] head_q;
	logic [7:0] s_awaddr = 8'h00, s_araddr = 8'h00;
	logic [31:0] s_wdata = 32'h0, s_rdata;
	logic s_awvalid = 1'b0, s_wvalid = 1'b0, s_bready = 1'b0, s_arvalid = 1'b0, s_rready = 1'b0;
	logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
	logic [1:0] s_bresp, s_rresp;
	int miscompares = 0, n_tests = 0, n_seek = 0, n_gate = 0, n_idx = 0, n_sec = 0;
	int n_rel = 0;
	always #25 aclk = ~aclk;
	dtb_ctrl_model u_ctrl (.aclk, .go, .kind, .val, .hold, .tag_cyl, .tag_head, .tag_ctl, .bus_out);
	// inputs not listed as regs are held at their idle level
	dtb_port dut (.aclk, .aresetn, .tag_cyl, .tag_head, .tag_ctl, .bus_out, .bus_in_q,
		.panel_protect_sw, .motor_speed_ok, .first_seek_ok(1'b1), .on_cylinder,
		.fault_in, .seek_error_in(1'b0), .servo_index, .servo_slot, .amark_found,
		.seek_start_q, .seek_cyl_q, .head_q, .write_gate_q, .read_gate_q, .amark_enable_q,
		.offset_plus_q, .offset_minus_q, .strobe_early_q, .strobe_late_q, .release_q,
		.s_awaddr, .s_awvalid, .s_awready, .s_wdata, .s_wstrb(4'hF), .s_wvalid, .s_wready,
		.s_bresp, .s_bvalid, .s_bready, .s_araddr, .s_arvalid, .s_arready, .s_rdata,
		.s_rresp, .s_rvalid, .s_rready, .irq_q);
	// control-line levels packed for one compare
	wire [4:0] ctl_lv = {amark_enable_q, offset_plus_q, offset_minus_q,
		strobe_early_q, strobe_late_q};
	// event counters sampled mid-cycle, away from the launching edge
	always @(negedge aclk) begin
		n_seek += int'(seek_start_q === 1'b1);
		n_gate += int'(write_gate_q === 1'b1 || read_gate_q === 1'b1);
		n_idx += int'(bus_in_q[6] === 1'b1);
		n_sec += int'(bus_in_q[7] === 1'b1);
		n_rel += int'(release_q === 1'b1);
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			miscompares++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// handshakes are judged on values seen before the edge that takes them
	task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		logic aw, w, b;
		logic [1:0] r;
		b = 1'b0;
		@(posedge aclk);
		{s_awaddr, s_wdata, s_awvalid, s_wvalid, s_bready} <= {a, d, 3'b111};
		// the wait ends when s_bvalid is seen; only the watchdog ends one that never is
		while (!b) begin
			@(negedge aclk);
			{aw, w, b, r} = {s_awvalid & s_awready, s_wvalid & s_wready, s_bvalid, s_bresp};
			@(posedge aclk);
			if (aw) s_awvalid <= 1'b0;
			if (w) s_wvalid <= 1'b0;
		end
		s_bready <= 1'b0;
		chk({b, r}, {1'b1, er});
	endtask
	task automatic axr(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
		logic ar, r;
		logic [33:0] got;
		r = 1'b0;
		@(posedge aclk);
		{s_araddr, s_arvalid, s_rready} <= {a, 2'b11};
		while (!r) begin
			@(negedge aclk);
			{ar, r, got} = {s_arvalid & s_arready, s_rvalid, s_rresp, s_rdata};
			@(posedge aclk);
			if (ar) s_arvalid <= 1'b0;
		end
		s_rready <= 1'b0;
		chk(got[31:0], ed);
		chk({r, got[33:32]}, {1'b1, er});
	endtask
	task automatic cmd(input logic [1:0] k, input logic [9:0] v, input logic [3:0] h);
		@(posedge aclk);
		{kind, val, hold, go} <= {k, v, h, 1'b1};
		@(posedge aclk);
		go <= 1'b0;
		repeat (h + 9) @(posedge aclk); // tag span plus synchroniser and status lag
		@(negedge aclk);
	endtask
	task automatic t_addr();
		int s, g;
		axr(`DTB_REG_CONFIG, 32'h0000_0400, `DTB_RESP_OKAY);
		chk(bus_in_q, 8'h03);
		@(posedge aclk);
		on_cylinder <= 1'b0;
		repeat (3) @(negedge aclk);
		chk(bus_in_q, 8'h01);
		@(posedge aclk);
		on_cylinder <= 1'b1;
		chk({seek_cyl_q, head_q}, 17'h00000);
		axw(`DTB_REG_CONFIG, 32'h0000_0401, `DTB_RESP_OKAY);
		cmd(2'h1, 10'h2F5, 4'h8);
		chk(head_q, 5'h15);
		s = n_seek;
		cmd(2'h0, 10'h123, 4'h2);
		chk(seek_cyl_q, 12'h523);
		chk(n_seek - s, 1);
		cmd(2'h1, 10'h187, 4'h8);
		s = n_seek;
		cmd(2'h0, 10'h3FF, 4'h2);
		chk(n_seek - s, 0);
		chk(bus_in_q[2], 1'b1);
		g = n_gate;
		cmd(2'h2, 10'h003, 4'h6);
		chk(n_gate - g, 0);
		cmd(2'h2, 10'h040, 4'h2);
		chk({bus_in_q[2], seek_cyl_q, head_q}, 0);
		chk(n_seek - s, 1);
	endtask
	task automatic t_prot();
		int g;
		@(posedge aclk);
		panel_protect_sw <= 1'b1;
		g = n_gate;
		cmd(2'h2, 10'h001, 4'h6);
		chk(n_gate - g, 0);
		chk(bus_in_q[4:3], 2'b11);
		@(posedge aclk);
		panel_protect_sw <= 1'b0;
		cmd(2'h2, 10'h010, 4'h1);
		chk(bus_in_q[4:3], 2'b00);
		// a drive fault alone must raise protect as well
		@(posedge aclk);
		fault_in <= 1'b1;
		@(posedge aclk);
		fault_in <= 1'b0;
		repeat (2) @(negedge aclk);
		chk(bus_in_q[4:3], 2'b11);
		cmd(2'h2, 10'h010, 4'h1);
		axw(`DTB_REG_CONFIG, 32'h0000_0408, `DTB_RESP_OKAY);
		repeat (3) @(negedge aclk);
		chk(bus_in_q[4], 1'b1);
		axw(`DTB_REG_CONFIG, 32'h0000_0400, `DTB_RESP_OKAY);
		motor_speed_ok <= 1'b0;
		repeat (3) @(negedge aclk);
		chk({bus_in_q[4], bus_in_q[0]}, 2'b10);
		@(posedge aclk);
		motor_speed_ok <= 1'b1;
		cmd(2'h2, 10'h010, 4'h1);
	endtask
	task automatic t_amark();
		int g;
		g = n_gate;
		fork
			cmd(2'h2, 10'h022, 4'hC);
			begin
				repeat (9) @(posedge aclk);
				amark_found <= 1'b1;
				@(posedge aclk);
				amark_found <= 1'b0;
				repeat (2) @(negedge aclk);
				chk(bus_in_q[5], 1'b1);
			end
		join
		chk(n_gate > g, 1);
	endtask
	// offsets, strobes, mark enable and release under one control-select
	task automatic t_ctl();
		int r;
		r = n_rel;
		fork
			cmd(2'h2, 10'h3AC, 4'h6);
			begin
				repeat (8) @(posedge aclk);
				@(negedge aclk);
				chk(ctl_lv, 5'h1F);
			end
		join
		chk(ctl_lv, 5'h00);
		chk(n_rel - r, 1);
	endtask
	task automatic t_mark(input logic [31:0] cfg, input logic e);
		int i, x, y;
		axw(`DTB_REG_CONFIG, cfg, `DTB_RESP_OKAY);
		{x, y} = {n_idx, n_sec};
		for (i = 0; i < 9; i++) begin
			@(posedge aclk);
			{servo_index, servo_slot} <= {i == 0, i != 0};
			@(posedge aclk);
			{servo_index, servo_slot} <= 2'b00;
		end
		repeat (4) @(negedge aclk);
		chk(n_idx > x, e);
		chk(n_sec > y, e);
	endtask
	task automatic t_irq();
		axw(`DTB_REG_IRQ_CLR, 32'h0000_001F, `DTB_RESP_OKAY);
		axw(`DTB_REG_IRQ_EN, 32'h0000_0001, `DTB_RESP_OKAY);
		cmd(2'h0, 10'h005, 4'h2);
		chk(irq_q, 1'b1);
		axr(`DTB_REG_IRQ_STAT, 32'h0000_0001, `DTB_RESP_OKAY);
		axw(`DTB_REG_IRQ_CLR, 32'h0000_0001, `DTB_RESP_OKAY);
		axw(`DTB_REG_IRQ_EN, 32'h0000_0000, `DTB_RESP_OKAY);
		cmd(2'h0, 10'h006, 4'h2);
		chk(irq_q, 1'b0);
		axr(`DTB_REG_IRQ_STAT, 32'h0000_0001, `DTB_RESP_OKAY);
		axw(`DTB_REG_MAXCYL, 32'h0000_0004, `DTB_RESP_OKAY);
		axr(`DTB_REG_MAXCYL, 32'h0000_0004, `DTB_RESP_OKAY);
		cmd(2'h0, 10'h005, 4'h2);
		axr(`DTB_REG_IRQ_STAT, 32'h0000_0003, `DTB_RESP_OKAY);
		chk(bus_in_q[2], 1'b1);
		axr(8'h1C, 32'h0000_0000, `DTB_RESP_SLVERR);
		axw(8'h1C, 32'hFFFF_FFFF, `DTB_RESP_SLVERR);
	endtask
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	initial begin
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		t_addr();
		t_prot();
		t_amark();
		t_ctl();
		t_mark(32'h0000_0400, 1'b1);
		t_mark(32'h0000_0406, 1'b0);
		t_irq();
		report_and_stop();
	end
	// the whole run needs well under a thousand cycles
	initial begin
		repeat (4000) @(posedge aclk);
		miscompares++;
		report_and_stop();
	end
endmodule // tb
`default_nettype wire
